/* src/vst_map.svh */
// Purpose: constants for video standard timing select
// Assumes: codes and table figures as the format table gives them
// Notes:   vsync width in half lines
`ifndef VST_MAP_SVH
`define VST_MAP_SVH
`define VST_CODE_OFF      6'h00
`define VST_CODE_IN_ONLY0 6'h02
`define VST_CODE_IN_ONLY1 6'h34
`define VST_CODE_IN_ONLY2 6'h35
`define VST_CODE_IN_ONLY3 6'h36
`define VST_CODE_CUSTOM   6'h3e
`define VST_CODE_FOLLOW   6'h3f
`define VST_CTRL_HOST_BIT 1
`define VST_525_LINE_CLKS 13'h06b4
`define VST_625_LINE_CLKS 13'h06c0
`define VST_SD_ACT_CLKS   12'h5a0
`define VST_SD_HSYNC_CLKS 9'h07f
`define VST_525_LINES     11'h20d
`define VST_525_ACT_LINES 11'h1e6
`define VST_525_VSYNC     5'h06
`define VST_625_LINES     11'h271
`define VST_625_ACT_LINES 11'h240
`define VST_625_VSYNC     5'h05
`endif

/* src/vst_pkg.sv */
// Purpose: types for video standard timing select
// Assumes: none
// Notes:   vsync width counted in half lines
package vst_pkg;
  typedef struct packed {
    logic [12:0] clks_per_line;
    logic [11:0] active_clks;
    logic [8:0]  hsync_clks;
    logic        hsync_tri;
    logic [10:0] lines_per_frame;
    logic [10:0] active_lines;
    logic [4:0]  vsync_half_lines;
    logic        interlaced;
  } vst_timing_type;

  typedef struct packed {
    logic [5:0]     pin_s1;
    logic [5:0]     pin_s2;
    logic [5:0]     code;
    logic [5:0]     det_code;
    logic           det_valid;
    logic           valid;
    vst_timing_type timing;
  } vst_state_type;
endpackage

/* src/vst_select.sv */
// Purpose: pick output video standard and drive its timing parameters
// Assumes: frame_start and detector inputs are on clk; select pins asynchronous
// Notes:   unknown or input-only codes give valid low and zero timing
`timescale 1ns/1ps
`include "vst_map.svh"
module vst_select
  import vst_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           arst_n,
  input  wire logic [5:0]     video_standard_code_pins,
  input  wire logic [5:0]     video_standard_code_host,
  input  wire logic [7:0]     video_control,
  input  wire vst_timing_type custom_timing,
  input  wire logic           ref_present,
  input  wire logic [5:0]     ref_detected_code,
  input  wire logic           frame_start,
  output logic [5:0]          active_code,
  output logic                detected_valid,
  output logic [5:0]          detected_code,
  output logic                timing_valid,
  output vst_timing_type      timing
);
  vst_state_type state_reg;
  vst_state_type state_next;

  function automatic vst_timing_type lut(input logic [5:0] c);
    vst_timing_type t;
    t = '0;
    case (c)
      6'h01: t = '{13'h038e, 12'h300, 9'h043, 1'b0, 11'h20d, 11'h1e6, 5'h06, 1'b1};
      6'h03: t = '{`VST_525_LINE_CLKS, `VST_SD_ACT_CLKS, `VST_SD_HSYNC_CLKS, 1'b0,
                   `VST_525_LINES, `VST_525_ACT_LINES, `VST_525_VSYNC, 1'b1};
      6'h04: t = '{`VST_625_LINE_CLKS, `VST_SD_ACT_CLKS, `VST_SD_HSYNC_CLKS, 1'b0,
                   `VST_625_LINES, `VST_625_ACT_LINES, `VST_625_VSYNC, 1'b1};
      6'h05: t = '{13'h08f0, 12'h780, 9'h0a9, 1'b0, 11'h20d, 11'h1e6, 5'h06, 1'b1};
      6'h06: t = '{13'h0900, 12'h780, 9'h0a9, 1'b0, 11'h271, 11'h240, 5'h05, 1'b1};
      6'h07: t = '{13'h0d68, 12'hb40, 9'h0fc, 1'b0, 11'h20d, 11'h1e6, 5'h06, 1'b1};
      6'h08: t = '{13'h0d80, 12'hb40, 9'h0fc, 1'b0, 11'h271, 11'h240, 5'h05, 1'b1};
      6'h09: t = '{13'h06b4, 12'h5a0, 9'h07f, 1'b0, 11'h20d, 11'h1e3, 5'h0c, 1'b0};
      6'h0a: t = '{13'h06c0, 12'h5a0, 9'h07f, 1'b0, 11'h271, 11'h240, 5'h0a, 1'b0};
      6'h0b, 6'h0c: t = '{13'h0672, 12'h500, 9'h050, 1'b1, 11'h2ee, 11'h2d0, 5'h0a, 1'b0};
      6'h0d: t = '{13'h07bc, 12'h500, 9'h050, 1'b1, 11'h2ee, 11'h2d0, 5'h0a, 1'b0};
      6'h0e, 6'h0f: t = '{13'h0ce4, 12'h500, 9'h050, 1'b1, 11'h2ee, 11'h2d0, 5'h0a, 1'b0};
      6'h10: t = '{13'h0f78, 12'h500, 9'h050, 1'b1, 11'h2ee, 11'h2d0, 5'h0a, 1'b0};
      6'h11, 6'h12: t = '{13'h101d, 12'h500, 9'h050, 1'b1, 11'h2ee, 11'h2d0, 5'h0a, 1'b0};
      6'h13, 6'h14: t = '{13'h0898, 12'h780, 9'h050, 1'b1, 11'h465, 11'h40b, 5'h0a, 1'b1};
      6'h15, 6'h16, 6'h1d, 6'h1f:
        t = '{13'h0898, 12'h780, 9'h050, 1'b1, 11'h465, 11'h438, 5'h0a, 1'b0};
      6'h17, 6'h21: t = '{13'h0a50, 12'h780, 9'h050, 1'b1, 11'h465, 11'h438, 5'h0a, 1'b0};
      6'h19, 6'h1a, 6'h1e, 6'h20:
        t = '{13'h0898, 12'h780, 9'h050, 1'b1, 11'h465, 11'h438, 5'h0a, 1'b1};
      6'h1b, 6'h22: t = '{13'h0a50, 12'h780, 9'h050, 1'b1, 11'h465, 11'h438, 5'h0a, 1'b1};
      6'h23: t = '{13'h0abe, 12'h780, 9'h050, 1'b1, 11'h465, 11'h438, 5'h0a, 1'b0};
      6'h24: t = '{13'h0abe, 12'h780, 9'h050, 1'b1, 11'h465, 11'h438, 5'h0a, 1'b1};
      default: t = '0;
    endcase
    return t;
  endfunction

  // Codes this generator can actually produce on its outputs
  function automatic logic out_ok(input logic [5:0] c);
    logic ok;
    ok = 1'b0;
    case (c)
      `VST_CODE_OFF, `VST_CODE_IN_ONLY0, `VST_CODE_IN_ONLY1,
      `VST_CODE_IN_ONLY2, `VST_CODE_IN_ONLY3: ok = 1'b0;
      `VST_CODE_CUSTOM, `VST_CODE_FOLLOW: ok = 1'b1;
      default: ok = (lut(c) != '0);
    endcase
    return ok;
  endfunction

  always_comb begin
    logic [5:0] sel;
    sel = '0;
    state_next = state_reg;
    state_next.pin_s1 = video_standard_code_pins;
    state_next.pin_s2 = state_reg.pin_s1;
    // Host field used when video_control bit 1 is set, else synced pins; pins still expected driven by board
    sel = video_control[`VST_CTRL_HOST_BIT] ? video_standard_code_host
                                            : state_reg.pin_s2;
    // Detector result tracked every cycle, no host action needed
    state_next.det_valid = ref_present && (ref_detected_code != `VST_CODE_OFF)
                           && (lut(ref_detected_code) != '0
                               || ref_detected_code == `VST_CODE_IN_ONLY0);
    state_next.det_code = ref_present ? ref_detected_code : `VST_CODE_OFF;
    // Switch only at frame start to avoid a torn frame
    if (frame_start) begin
      state_next.code = sel;
      state_next.valid = out_ok(sel);
      case (sel)
        `VST_CODE_CUSTOM: state_next.timing = custom_timing;
        `VST_CODE_FOLLOW: begin
          state_next.timing = out_ok(state_reg.det_code) ? lut(state_reg.det_code) : '0;
          state_next.valid = state_reg.det_valid && out_ok(state_reg.det_code);
        end
        default: state_next.timing = out_ok(sel) ? lut(sel) : '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign active_code    = state_reg.code;
  assign detected_valid = state_reg.det_valid;
  assign detected_code  = state_reg.det_code;
  assign timing_valid   = state_reg.valid;
  assign timing         = state_reg.timing;
endmodule

/* testbench/vst_select_props.sv */
// Purpose: port checks for vst_select
// Assumes: host code path on clk
// Notes:   pin path judged by bench
`timescale 1ns/1ps
module vst_select_props
  import vst_pkg::*;
(
  input wire logic           clk,
  input wire logic           arst_n,
  input wire logic           frame_start,
  input wire logic           ref_present,
  input wire logic [5:0]     video_standard_code_host,
  input wire logic [5:0]     ref_detected_code,
  input wire logic [7:0]     video_control,
  input wire vst_timing_type custom_timing,
  input wire vst_timing_type timing,
  input wire logic [5:0]     active_code,
  input wire logic [5:0]     detected_code,
  input wire logic           detected_valid,
  input wire logic           timing_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire       hs = frame_start && video_control[1];
  wire [5:0] hc = video_standard_code_host;
  a_host_code: assert property (hs |=> active_code == $past(hc)) else $error("code");
  a_frame_hold: assert property (!frame_start |=> $stable(timing)) else $error("hold");
  a_std_525: assert property (hs && hc == 6'h03 |=> timing.clks_per_line == 13'h06b4 &&
    timing.active_clks == 12'h5a0 && timing.hsync_clks == 9'h07f) else $error("525");
  a_std_625: assert property (hs && hc == 6'h04 |=> timing.clks_per_line == 13'h06c0 &&
    timing.vsync_half_lines == 5'h05 && timing.active_lines == 11'h240) else $error("625");
  a_input_only: assert property (hs && hc inside {6'h02, 6'h34, 6'h35, 6'h36}
    |=> !timing_valid) else $error("input only");
  a_custom_copy: assert property (hs && hc == 6'h3e
    |=> timing == $past(custom_timing)) else $error("custom");
  a_follow_ref: assert property (hs && hc == 6'h3f && detected_valid && detected_code == 6'h04
    |=> timing.clks_per_line == 13'h06c0) else $error("follow");
  a_detect_ref: assert property (ref_present && ref_detected_code == 6'h03
    |=> detected_valid && detected_code == 6'h03) else $error("detect");
endmodule
bind vst_select vst_select_props i_vst_select_props (.*);

/* testbench/vst_ref_src.sv */
// Purpose: incoming reference as seen by the detector
// Assumes: frame pulse on request
// Notes:   absent reference shows inverted last code
`timescale 1ns/1ps
module vst_ref_src (
  input  wire logic       clk,
  input  wire logic       on,
  input  wire logic       go,
  input  wire logic [5:0] code,
  output logic            ref_present,
  output logic            frame_start,
  output logic [5:0]      ref_detected_code
);
  logic [5:0] last_reg = 6'h00;
  always @(posedge clk) if (on) last_reg <= code;
  assign ref_present = on;
  assign frame_start = go;
  assign ref_detected_code = on ? code : ~last_reg;
endmodule

/* testbench/tb.sv */
// Purpose: self-checking bench for vst_select
// Assumes: pins synced in two stages
// Notes:   checks valid, code and line length per frame
`timescale 1ns/1ps
module tb
  import vst_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, on = 1'b0, go = 1'b0, fs_d = 1'b0, rp, fs, dv, tv;
  logic [5:0] pins = 6'h00, host = 6'h00, rcode = 6'h00, ac, dc, dc0;
  logic [5:0] io[4] = '{6'h02, 6'h34, 6'h35, 6'h36};
  logic [7:0] ctrl = 8'h00;
  logic [15:0] lf = 16'h9809;
  logic [19:0] exq[$];
  vst_timing_type cust = '0, tim;
  int mismatches = 0, checked = 0;
  always #4 clk = ~clk;
  vst_ref_src i_vst_ref_src (.clk(clk), .on(on), .go(go), .code(rcode), .ref_present(rp),
    .frame_start(fs), .ref_detected_code(dc0));
  vst_select i_vst_select (.clk(clk), .arst_n(arst_n), .video_standard_code_pins(pins),
    .video_standard_code_host(host), .video_control(ctrl), .custom_timing(cust),
    .ref_present(rp), .ref_detected_code(dc0), .frame_start(fs), .active_code(ac),
    .detected_valid(dv), .detected_code(dc), .timing_valid(tv), .timing(tim));
  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] want);
    checked++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Unused select source gets random values: must be ignored
  task automatic frame(input logic h, input logic [5:0] c, input logic v, input logic [12:0] n);
    @(posedge clk) #1;
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    ctrl = {6'h00, h, 1'b0};
    host = h ? c : lf[5:0];
    pins = h ? lf[11:6] : c;
    repeat (3) @(posedge clk);
    #1 go = 1'b1;
    exq.push_back({v, c, n});
    @(posedge clk) #1 go = 1'b0;
  endtask
  always @(posedge clk) fs_d <= fs;
  always @(negedge clk) if (fs_d) chk("frame", {tv, ac, tim.clks_per_line}, exq.pop_front());
  initial begin
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    cust = {lf, lf, lf, lf[14:0]};
    on = 1'b1;
    rcode = 6'h04;
    frame(1'b0, 6'h03, 1'b1, 13'd1716);
    frame(1'b1, 6'h04, 1'b1, 13'd1728);
    foreach (io[i]) frame(1'b1, io[i], 1'b0, 13'd0);
    frame(1'b1, 6'h3e, 1'b1, cust.clks_per_line);
    frame(1'b1, 6'h3f, 1'b1, 13'd1728);
    frame(1'b1, 6'h00, 1'b0, 13'd0);
    rcode = 6'h03;
    repeat (2) @(posedge clk);
    #1 chk("detect", {13'h0000, dv, dc}, {13'h0001, 6'h03});
    rcode = 6'h02;
    repeat (2) @(posedge clk);
    #1 chk("detect", {13'h0000, dv, dc}, {13'h0001, 6'h02});
    on = 1'b0;
    frame(1'b1, 6'h3f, 1'b0, 13'd0);
    repeat (2) @(posedge clk);
    report_and_stop();
  end
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
endmodule
